// >>> shared/epac_cfg.svh
// Constants for the emulated PHY expansion and special control block
// Function
// - Duplex pin equal to polarity strap: ability 0010 at 10M, 1000 at 100M.
// - Duplex pin unequal to polarity strap: ability 0001 at 10M, 0100 at 100M.
// - Parallel detection fault bit 4 of expansion always reads zero.
// - Partner and local next-page bits 3 and 2 always read zero.
// - Page-received bit 1 clears on read and reset, sets after negotiation.
// - Partner negotiation-able bit 0 reads one unless no common abilities.
// - Registers are 32 bits, upper 16 zero; serial access shows 16 bits.
// - Loopback bit 14 returns port-0 transmit into switch, not to MAC.
// - Loopback works even while the emulated PHY isolate bit is set.
// - Double-rate bit 10 turns 100 Mbps MII PHY rate into 200 Mbps.
// - Read-only bits 9:8 report port-0 mode: MII MAC, MII PHY, RMII PHY.
// - Collision test bit 7 asserts fabric collision during every transmit.
// - Bit 6 sets reference clock pin direction: zero input, one output.
// - Bit 5 picks 16 mA drive in RMII or 200M modes, else fixed 12 mA.
// - Speed and duplex polarity straps are captured at reset release.
`ifndef EPAC_CFG_SVH
`define EPAC_CFG_SVH
`define EPAC_ADDR_W 9
`define EPAC_OFS_EXP 9'h1d8
`define EPAC_OFS_SCS 9'h1dc
`define EPAC_ABIL_10F 4'b0010
`define EPAC_ABIL_100F 4'b1000
`define EPAC_ABIL_10H 4'b0001
`define EPAC_ABIL_100H 4'b0100
`define EPAC_BIT_PGRX 1
`define EPAC_BIT_ANABLE 0
`define EPAC_BIT_LOOP 14
`define EPAC_BIT_DRATE 10
`define EPAC_BIT_MODE_LO 8
`define EPAC_BIT_COLT 7
`define EPAC_BIT_CLKDIR 6
`define EPAC_BIT_CLKSTR 5
`define EPAC_MODE_MII_MAC 2'b00
`define EPAC_MODE_MII_PHY 2'b01
`define EPAC_MODE_RMII_PHY 2'b10
`define EPAC_EXP_LIVE_MASK 16'h0003
`endif

// >>> shared/epac_pkg.sv
// Types for the emulated PHY expansion and special control block
package epac_pkg;
  // Register access from memory map or serial management
  typedef struct packed {
    logic rd;
    logic wr;
    logic [8:0] addr;
    logic [31:0] wdata;
  } epac_req_t;
  // Port-0 fabric steering outputs
  typedef struct packed {
    logic to_mac;
    logic to_switch;
    logic collision;
  } epac_path_t;
  typedef enum logic [2:0] {
    EPAC_AN_IDLE = 3'b001,
    EPAC_AN_RUN = 3'b010,
    EPAC_AN_DONE = 3'b100
  } epac_an_state_t;
endpackage

// >>> rtl/epac_top.sv
// Emulated PHY expansion, special control and port-0 test logic
`timescale 1ns/1ps
`include "epac_cfg.svh"
module epac_top
  import epac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register access
  input wire epac_req_t req,
  input wire logic serial_access,
  output logic [31:0] rdata,
  output logic rvalid,
  // Straps, pins and mode
  input wire logic speed_strap,
  input wire logic duplex_pol_strap,
  input wire logic port0_duplex_pin,
  input wire logic [1:0] port0_mode,
  input wire logic double_rate_default,
  input wire logic clk_dir_default,
  input wire logic clk_str_default,
  // Negotiation
  input wire logic an_restart,
  input wire logic [3:0] local_ability,
  input wire logic emulated_phy_isolate_bit,
  // Port-0 fabric transmit
  input wire logic fabric_tx_en,
  output epac_path_t path,
  output logic [3:0] partner_ability,
  output logic rate_200,
  output logic port0_reference_clock_pin_oe,
  output logic clk_drive_16ma
);
  logic strap_speed;
  logic strap_pol;
  logic strap_take;
  logic page_rx;
  logic an_able;
  logic loop_en;
  logic drate;
  logic colt;
  logic clkdir;
  logic clkstr;
  logic [3:0] next_ability;
  logic [15:0] exp_val;
  logic [15:0] scs_val;
  logic [31:0] next_rdata;
  epac_an_state_t an_state;

  // ====================================================================
  // Strap capture
  // Straps are sampled on the first clock after reset release, so an
  // asynchronous reset never loads a port value.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      strap_take <= 1'b1;
    else
      strap_take <= 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      strap_speed <= 1'b0;
      strap_pol <= 1'b0;
    end
    else if (strap_take)
    begin
      strap_speed <= speed_strap;
      strap_pol <= duplex_pol_strap;
    end
  end

  // ====================================================================
  // Emulated partner ability
  always_comb
  begin
    if (port0_duplex_pin == strap_pol)
      next_ability = strap_speed ? `EPAC_ABIL_100F : `EPAC_ABIL_10F;
    else
      next_ability = strap_speed ? `EPAC_ABIL_100H : `EPAC_ABIL_10H;
  end

  // ====================================================================
  // Negotiation sequencing
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      an_state <= EPAC_AN_RUN;
    else
      case (an_state)
        EPAC_AN_IDLE: if (an_restart) an_state <= EPAC_AN_RUN;
        EPAC_AN_RUN: an_state <= EPAC_AN_DONE;
        EPAC_AN_DONE: an_state <= EPAC_AN_IDLE;
        default: an_state <= EPAC_AN_IDLE;
      endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      an_able <= 1'b1;
      partner_ability <= 4'h0;
    end
    else if (an_state == EPAC_AN_DONE)
    begin
      an_able <= |(local_ability & next_ability);
      partner_ability <= next_ability;
    end
  end

  wire exp_read = req.rd && req.addr == `EPAC_OFS_EXP;

  // Set wins over a read in the same cycle, so a page is never lost
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      page_rx <= 1'b0;
    else if (an_state == EPAC_AN_DONE)
      page_rx <= 1'b1;
    else if (exp_read)
      page_rx <= 1'b0;
  end

  // ====================================================================
  // Control register writes
  wire scs_write = req.wr && req.addr == `EPAC_OFS_SCS;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      loop_en <= 1'b0;
      colt <= 1'b0;
      drate <= 1'b0;
      clkdir <= 1'b0;
      clkstr <= 1'b0;
    end
    else if (strap_take)
    begin
      drate <= double_rate_default;
      clkdir <= clk_dir_default;
      clkstr <= clk_str_default;
    end
    else if (scs_write)
    begin
      loop_en <= req.wdata[`EPAC_BIT_LOOP];
      colt <= req.wdata[`EPAC_BIT_COLT];
      drate <= req.wdata[`EPAC_BIT_DRATE];
      clkdir <= req.wdata[`EPAC_BIT_CLKDIR];
      clkstr <= req.wdata[`EPAC_BIT_CLKSTR];
    end
  end

  // ====================================================================
  // Read data
  always_comb
  begin
    exp_val = 16'h0000;
    exp_val[`EPAC_BIT_PGRX] = page_rx;
    exp_val[`EPAC_BIT_ANABLE] = an_able;
    scs_val = 16'h0000;
    scs_val[`EPAC_BIT_LOOP] = loop_en;
    scs_val[`EPAC_BIT_DRATE] = drate;
    scs_val[`EPAC_BIT_MODE_LO +: 2] = port0_mode;
    scs_val[`EPAC_BIT_COLT] = colt;
    scs_val[`EPAC_BIT_CLKDIR] = clkdir;
    scs_val[`EPAC_BIT_CLKSTR] = clkstr;
    next_rdata = 32'h0000_0000;
    if (req.addr == `EPAC_OFS_EXP)
      next_rdata[15:0] = exp_val;
    else if (req.addr == `EPAC_OFS_SCS)
      next_rdata[15:0] = scs_val;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata <= 32'h0000_0000;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= req.rd;
      // Serial side is 16 bits wide; upper half is always zero anyway
      rdata <= req.rd ? (serial_access ? {16'h0000, next_rdata[15:0]}
                                       : next_rdata) : 32'h0000_0000;
    end
  end

  // ====================================================================
  // Port-0 fabric steering and pin controls
  // Isolate gates only the MAC path, not the switch path: loopback must keep working.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      path <= '0;
      rate_200 <= 1'b0;
      port0_reference_clock_pin_oe <= 1'b0;
      clk_drive_16ma <= 1'b0;
    end
    else
    begin
      path.to_mac <= fabric_tx_en && !loop_en
                     && !emulated_phy_isolate_bit;
      path.to_switch <= fabric_tx_en && loop_en;
      path.collision <= fabric_tx_en && colt;
      rate_200 <= drate && port0_mode == `EPAC_MODE_MII_PHY;
      port0_reference_clock_pin_oe <= clkdir;
      clk_drive_16ma <= clkstr && (port0_mode == `EPAC_MODE_RMII_PHY
                        || (drate && port0_mode == `EPAC_MODE_MII_PHY));
    end
  end

  // ====================================================================
  // Checks
  sequence tx_with_loop;
    fabric_tx_en && loop_en;
  endsequence

  loop_to_switch_a: assert property (@(posedge clk) disable iff (reset)
    tx_with_loop |=> path.to_switch && !path.to_mac)
    else $error("loopback frame escaped to MAC");
  loop_isolate_a: assert property (@(posedge clk) disable iff (reset)
    tx_with_loop and emulated_phy_isolate_bit |=> path.to_switch)
    else $error("loopback blocked by isolate");
  coll_test_a: assert property (@(posedge clk) disable iff (reset)
    fabric_tx_en && colt |=> path.collision)
    else $error("collision test not asserted");
  page_clear_a: assert property (@(posedge clk) disable iff (reset)
    exp_read && an_state != EPAC_AN_DONE |=> !page_rx)
    else $error("page received not cleared by read");
  exp_fixed_a: assert property (@(posedge clk) disable iff (reset)
    rvalid |-> rdata[31:16] == 16'h0000)
    else $error("reserved upper half not zero");
  // Checked on the read data itself, so a stray bit anywhere on the path
  // shows up
  exp_zero_a: assert property (@(posedge clk) disable iff (reset)
    exp_read |=> (rdata[15:0] & ~`EPAC_EXP_LIVE_MASK) == 16'h0000)
    else $error("expansion fixed bits not zero");
  ability_map_a: assert property (@(posedge clk) disable iff (reset)
    an_state == EPAC_AN_DONE && port0_duplex_pin == strap_pol
    |=> partner_ability == (strap_speed ? `EPAC_ABIL_100F
                                        : `EPAC_ABIL_10F))
    else $error("full duplex ability wrong");
  clkdir_a: assert property (@(posedge clk) disable iff (reset)
    scs_write && !strap_take
    |=> ##1 port0_reference_clock_pin_oe
            == $past(req.wdata[`EPAC_BIT_CLKDIR], 2))
    else $error("clock pin direction wrong");
endmodule

// >>> tb/epac_mac_model.sv
// Far-side MAC model: counts cycles of port-0 traffic that reach it
`timescale 1ns/1ps
module epac_mac_model
  import epac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Port-0 traffic
  input wire epac_path_t path,
  output logic own_rx_en,
  output logic [15:0] rx_cycles
);
  // ==========================================
  // Receive side
  // Held set so half-duplex loopback never drops own transmit
  assign own_rx_en = 1'b1;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rx_cycles <= 16'h0000;
    else if (path.to_mac)
      rx_cycles <= rx_cycles + 16'h0001;
  end
endmodule

// >>> tb/epac_top_bench.sv
// Self-checking bench for the emulated PHY control block
`timescale 1ns/1ps
module epac_top_bench;
  import epac_pkg::*;
  // ==========================================
  // Signals
  logic clk = 0;
  logic reset = 1;
  epac_req_t req = '0;
  logic ser = 0, spd = 0, pol = 0, dup = 0, an_rst = 0, iso = 0, tx = 0;
  logic [1:0] mode = 2'b10;
  logic [3:0] loc = 4'hf;
  logic [31:0] rdata, d;
  logic rvalid, r200, oe, d16;
  logic [3:0] pa;
  logic [15:0] cnt, c;
  epac_path_t path;
  int num_errors = 0;
  int compares = 0;
  always #20 clk = ~clk;
  epac_top dut_u (.clk(clk), .reset(reset), .req(req), .serial_access(ser),
    .rdata(rdata), .rvalid(rvalid), .speed_strap(spd),
    .duplex_pol_strap(pol), .port0_duplex_pin(dup), .port0_mode(mode),
    .double_rate_default(1'b0), .clk_dir_default(1'b0),
    .clk_str_default(1'b0), .an_restart(an_rst), .local_ability(loc),
    .emulated_phy_isolate_bit(iso), .fabric_tx_en(tx), .path(path),
    .partner_ability(pa), .rate_200(r200),
    .port0_reference_clock_pin_oe(oe), .clk_drive_16ma(d16));
  epac_mac_model mac_u (.clk(clk), .reset(reset), .path(path),
    .own_rx_en(), .rx_cycles(cnt));
  // ==========================================
  // Bus and check tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic s, input logic p, input logic pin);
    @(posedge clk);
    reset <= 1;
    spd <= s;
    pol <= p;
    dup <= pin;
    repeat (12) @(posedge clk);
    reset <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] q);
    int n;
    @(posedge clk);
    req.rd <= 1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 0;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, rvalid}, 32'h1);
    q = rdata;
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    @(posedge clk);
    req.wr <= 1;
    req.addr <= a;
    req.wdata <= v;
    @(posedge clk);
    req.wr <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic restart(input logic [3:0] l);
    @(posedge clk);
    loc <= l;
    an_rst <= 1;
    @(posedge clk);
    an_rst <= 0;
    repeat (4) @(posedge clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_abil;
    logic [3:0] e [4] = '{4'b0010, 4'b1000, 4'b0001, 4'b0100};
    for (int i = 0; i < 4; i++)
    begin
      do_reset(i[0], i[0], i[0] ^ i[1]);
      chk({28'h0, pa}, {28'h0, e[i]});
    end
    $display("test abilities done");
  endtask
  task automatic t_exp;
    rd(9'h1d8, d);
    chk(d, 32'h3);
    @(posedge clk);
    ser <= 1;
    rd(9'h1d8, d);
    chk(d, 32'h1);
    @(posedge clk);
    ser <= 0;
    restart(4'h0);
    rd(9'h1d8, d);
    chk(d, 32'h2);
    // A strap moved after reset release must not reach the partner
    @(posedge clk);
    spd <= 0;
    restart(4'hf);
    rd(9'h1d8, d);
    chk(d, 32'h3);
    chk({28'h0, pa}, 32'h4);
    $display("test expansion done");
  endtask
  task automatic t_ctrl;
    wr(9'h1dc, 32'hffff_ffff);
    rd(9'h1dc, d);
    chk(d, 32'h46e0);
    chk({29'h0, r200, oe, d16}, 32'h3);
    rd(9'h1e0, d);
    chk(d, 32'h0);
    for (int m = 0; m < 3; m++)
    begin
      @(posedge clk);
      mode <= m[1:0];
      wr(9'h1dc, 32'h0420);
      rd(9'h1dc, d);
      chk(d, 32'h420 | (m << 8));
      chk({29'h0, r200, oe, d16}, {29'h0, m == 1, 1'b0, m != 0});
    end
    // Plain 100 Mbps MII PHY: no double rate, drive fixed low
    @(posedge clk);
    mode <= 2'b01;
    wr(9'h1dc, 32'h20);
    chk({29'h0, r200, oe, d16}, 32'h0);
    $display("test control done");
  endtask
  task automatic t_path;
    @(posedge clk);
    tx <= 1;
    repeat (2) @(posedge clk);
    #1;
    chk({29'h0, path}, 32'h4);
    wr(9'h1dc, 32'h4000);
    c = cnt;
    chk({29'h0, path}, 32'h2);
    @(posedge clk);
    iso <= 1;
    wr(9'h1dc, 32'h4080);
    chk({29'h0, path}, 32'h3);
    chk({16'h0, cnt}, {16'h0, c});
    @(posedge clk);
    tx <= 0;
    iso <= 0;
    repeat (2) @(posedge clk);
    #1;
    chk({29'h0, path}, 32'h0);
    $display("test path done");
  endtask
  // ==========================================
  // Run control
  task automatic end_sim;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    t_abil;
    t_exp;
    t_ctrl;
    t_path;
    end_sim;
  end
  // About 140 cycles are needed; this 2500-cycle bound cuts a hang
  initial
  begin
    #100_000;
    num_errors++;
    end_sim;
  end
endmodule
